//--- src/bar_register_map.sv
// Purpose: register bank of the barometer, reached by the serial front end
// Assumes: front end delivers a start with address, then byte reads/writes
// Notes: read data appears one cycle after the read strobe
module bar_register_map #(
    parameter logic [7:0] IDENTITY = bar_pkg::IDENTITY_DEFAULT,
    parameter logic [7:0] AMP_TRIM = bar_pkg::AMP_TRIM_DEFAULT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_start,
    input wire logic [6:0] cmd_addr,
    input wire logic cmd_incr,
    input wire logic byte_wr,
    input wire logic [7:0] byte_wdata,
    input wire logic byte_rd,
    output logic [7:0] byte_rdata,
    output logic byte_rvalid,
    input wire logic sample_load,
    input wire logic [23:0] raw_pressure,
    input wire logic [15:0] raw_temperature,
    input wire logic [7:0] status_in,
    input wire logic [7:0] int_source_in,
    output logic [23:0] ref_pressure,
    output logic [9:0] pressure_avg_count,
    output logic [7:0] temperature_avg_count,
    output logic [7:0] control_one,
    output logic [7:0] control_two,
    output logic [7:0] control_three,
    output logic [7:0] interrupt_configuration,
    output logic [7:0] pressure_threshold_low,
    output logic [7:0] pressure_threshold_high,
    output logic [7:0] amplifier_control
);
    // register storage
    logic [7:0] averaging_configuration;
    logic [7:0] sample_status;
    logic [7:0] interrupt_source_flags;
    logic [23:0] pressure_result;
    logic [15:0] temperature_result;
    logic [6:0] addr_ptr;
    logic incr_mode;
    logic [23:0] pressure_sum;
    logic sum_valid;
    logic [15:0] temp_hold;

    // address of the current byte
    wire [6:0] acc_addr = addr_ptr;
    wire acc_any = byte_wr | byte_rd;
    wire [6:0] next_ptr = 7'(addr_ptr + 7'h01);

    // decide whether an address can be written
    function automatic logic is_writable(input logic [6:0] a);
        unique case (a)
            bar_pkg::A_REF_LOW, bar_pkg::A_REF_MID, bar_pkg::A_REF_HIGH,
            bar_pkg::A_AVG_CFG, bar_pkg::A_CTRL_ONE, bar_pkg::A_CTRL_TWO,
            bar_pkg::A_CTRL_THREE, bar_pkg::A_INT_CFG, bar_pkg::A_THS_LOW,
            bar_pkg::A_THS_HIGH, bar_pkg::A_AMPLIFIER_CONTROL: is_writable = 1'b1;
            default: is_writable = 1'b0;
        endcase
    endfunction

    // per-register write strobes
    // 7-bit write decode
    // read-only and reserved places never get a strobe
    wire wr_ok = byte_wr && is_writable(acc_addr);
    wire we_ref_low = wr_ok && acc_addr == bar_pkg::A_REF_LOW;
    wire we_ref_mid = wr_ok && acc_addr == bar_pkg::A_REF_MID;
    wire we_ref_high = wr_ok && acc_addr == bar_pkg::A_REF_HIGH;
    wire we_avg = wr_ok && acc_addr == bar_pkg::A_AVG_CFG;
    wire we_c1 = wr_ok && acc_addr == bar_pkg::A_CTRL_ONE;
    wire we_c2 = wr_ok && acc_addr == bar_pkg::A_CTRL_TWO;
    wire we_c3 = wr_ok && acc_addr == bar_pkg::A_CTRL_THREE;
    wire we_icfg = wr_ok && acc_addr == bar_pkg::A_INT_CFG;
    wire we_thl = wr_ok && acc_addr == bar_pkg::A_THS_LOW;
    wire we_thh = wr_ok && acc_addr == bar_pkg::A_THS_HIGH;
    wire we_amp = wr_ok && acc_addr == bar_pkg::A_AMPLIFIER_CONTROL;

    // read mux
    // 7-bit read decode
    logic [7:0] read_value;
    always_comb begin
        unique case (acc_addr)
            bar_pkg::A_REF_LOW: read_value = ref_pressure[7:0];
            bar_pkg::A_REF_MID: read_value = ref_pressure[15:8];
            bar_pkg::A_REF_HIGH: read_value = ref_pressure[23:16];
            bar_pkg::A_IDENTITY: read_value = IDENTITY;
            bar_pkg::A_AVG_CFG: read_value = averaging_configuration;
            bar_pkg::A_CTRL_ONE: read_value = control_one;
            bar_pkg::A_CTRL_TWO: read_value = control_two;
            bar_pkg::A_CTRL_THREE: read_value = control_three;
            bar_pkg::A_INT_CFG: read_value = interrupt_configuration;
            bar_pkg::A_INT_SRC: read_value = interrupt_source_flags;
            bar_pkg::A_THS_LOW: read_value = pressure_threshold_low;
            bar_pkg::A_THS_HIGH: read_value = pressure_threshold_high;
            bar_pkg::A_STATUS: read_value = sample_status;
            bar_pkg::A_PRESS_LOW: read_value = pressure_result[7:0];
            bar_pkg::A_PRESS_MID: read_value = pressure_result[15:8];
            bar_pkg::A_PRESS_HIGH: read_value = pressure_result[23:16];
            bar_pkg::A_TEMP_LOW: read_value = temperature_result[7:0];
            bar_pkg::A_TEMP_HIGH: read_value = temperature_result[15:8];
            bar_pkg::A_AMPLIFIER_CONTROL: read_value = amplifier_control;
            default: read_value = 8'h00; // reserved reads as zero
        endcase
    end

    // address pointer, start has priority over a byte in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_ptr <= 7'h00;
            incr_mode <= 1'b0;
        end else if (cmd_start) begin
            addr_ptr <= cmd_addr;
            incr_mode <= cmd_incr;
        end else if (acc_any && incr_mode) begin
            addr_ptr <= next_ptr;
        end
    end

    // read data out
    always_ff @(posedge clk) begin
        if (!rstn) begin
            byte_rdata <= 8'h00;
            byte_rvalid <= 1'b0;
        end else begin
            byte_rvalid <= byte_rd && !cmd_start;
            if (byte_rd && !cmd_start) begin
                byte_rdata <= read_value;
            end
        end
    end

    // reference pressure bytes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ref_pressure[7:0] <= bar_pkg::RST_ZERO;
            ref_pressure[15:8] <= bar_pkg::RST_ZERO;
            ref_pressure[23:16] <= bar_pkg::RST_ZERO;
        end else begin
            if (we_ref_low && !cmd_start) ref_pressure[7:0] <= byte_wdata;
            if (we_ref_mid && !cmd_start) ref_pressure[15:8] <= byte_wdata;
            if (we_ref_high && !cmd_start) ref_pressure[23:16] <= byte_wdata;
        end
    end

    // averaging configuration
    always_ff @(posedge clk) begin
        if (!rstn) begin
            averaging_configuration <= bar_pkg::RST_AVG_CFG;
        end else if (we_avg && !cmd_start) begin
            averaging_configuration <= byte_wdata;
        end
    end

    // control and interrupt setup registers
    // read/write control and threshold places
    always_ff @(posedge clk) begin
        if (!rstn) begin
            control_one <= bar_pkg::RST_ZERO;
            control_two <= bar_pkg::RST_ZERO;
            control_three <= bar_pkg::RST_ZERO;
            interrupt_configuration <= bar_pkg::RST_ZERO;
            pressure_threshold_low <= bar_pkg::RST_ZERO;
            pressure_threshold_high <= bar_pkg::RST_ZERO;
        end else if (!cmd_start) begin
            if (we_c1) control_one <= byte_wdata;
            if (we_c2) control_two <= byte_wdata;
            if (we_c3) control_three <= byte_wdata;
            if (we_icfg) interrupt_configuration <= byte_wdata;
            if (we_thl) pressure_threshold_low <= byte_wdata;
            if (we_thh) pressure_threshold_high <= byte_wdata;
        end
    end

    // calibration register
    // reloaded from trim at every reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            amplifier_control <= AMP_TRIM;
        end else if (we_amp && !cmd_start) begin
            amplifier_control <= byte_wdata;
        end
    end

    // status and source follow the engine, host writes have no path here
    // read-only status and source
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sample_status <= bar_pkg::RST_ZERO;
            interrupt_source_flags <= bar_pkg::RST_ZERO;
        end else begin
            sample_status <= status_in;
            interrupt_source_flags <= int_source_in;
        end
    end

    // temperature waits one cycle to line up with the adder
    always_ff @(posedge clk) begin
        if (!rstn) begin
            temp_hold <= 16'h0000;
        end else if (sample_load) begin
            temp_hold <= raw_temperature;
        end
    end

    // output registers load from the adder
    // read-only results
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pressure_result <= 24'h000000;
            temperature_result <= 16'h0000;
        end else if (sum_valid) begin
            pressure_result <= pressure_sum;
            temperature_result <= temp_hold;
        end
    end

    bar_ref_adder u_adder (
        .clk(clk),
        .rstn(rstn),
        .load(sample_load),
        .raw_pressure(raw_pressure),
        .ref_pressure(ref_pressure),
        .pressure_sum(pressure_sum),
        .sum_valid(sum_valid)
    );

    // averaging fields of the configuration byte
    wire [3:0] avgp_field = averaging_configuration[bar_pkg::AVGP_LSB +: bar_pkg::AVGP_W];
    wire [2:0] avgt_field = averaging_configuration[bar_pkg::AVGT_LSB +: bar_pkg::AVGT_W];

    bar_avg_decode u_avg (
        .avgp_code(avgp_field),
        .avgt_code(avgt_field),
        .pressure_count(pressure_avg_count),
        .temperature_count(temperature_avg_count)
    );

    // checks
    sequence seq_read_at(logic [6:0] a);
        byte_rd && !cmd_start && addr_ptr == a;
    endsequence

    sequence seq_write_at(logic [6:0] a);
        byte_wr && !cmd_start && addr_ptr == a;
    endsequence

    chk_identity_fixed: assert property (@(posedge clk) disable iff (!rstn)
        seq_read_at(bar_pkg::A_IDENTITY) |=> byte_rvalid && byte_rdata == IDENTITY)
        else $error("identity read wrong");

    chk_ref_low_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_REF_LOW) |=> ref_pressure[7:0] == $past(byte_wdata))
        else $error("reference low byte not written");

    chk_ref_mid_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_REF_MID) |=> ref_pressure[15:8] == $past(byte_wdata))
        else $error("reference mid byte not written");

    chk_ref_high_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_REF_HIGH) |=> ref_pressure[23:16] == $past(byte_wdata))
        else $error("reference high byte not written");

    chk_avg_reset_value: assert property (@(posedge clk)
        !rstn |=> averaging_configuration == 8'h7a && pressure_avg_count == 10'h200)
        else $error("averaging reset wrong");

    chk_ptr_advance: assert property (@(posedge clk) disable iff (!rstn)
        (byte_rd || byte_wr) && !cmd_start && incr_mode |=> addr_ptr == 7'($past(addr_ptr) + 7'h01))
        else $error("address did not advance");

    chk_ptr_hold: assert property (@(posedge clk) disable iff (!rstn)
        cmd_start ##1 (!cmd_start && !incr_mode)[*2] |-> addr_ptr == $past(cmd_addr, 2))
        else $error("address moved without increment");

    chk_ro_ignore: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_IDENTITY) ##[1:4] seq_read_at(bar_pkg::A_IDENTITY)
        |=> byte_rdata == IDENTITY)
        else $error("read-only place changed");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        byte_rd && !cmd_start && addr_ptr inside {[7'h11:7'h1f]} |=> byte_rdata == 8'h00)
        else $error("reserved place not zero");

    chk_result_load: assert property (@(posedge clk) disable iff (!rstn)
        sample_load |=> ##1 pressure_result == 24'($past(raw_pressure, 2) + $past(ref_pressure, 2))
        && temperature_result == $past(raw_temperature, 2))
        else $error("result not loaded");

    chk_amp_reload: assert property (@(posedge clk)
        !rstn |=> amplifier_control == AMP_TRIM)
        else $error("calibration not reloaded");

    sequence seq_write_ro;
        byte_wr && !cmd_start && !is_writable(addr_ptr);
    endsequence

    chk_avgt_power: assert property (@(posedge clk) disable iff (!rstn)
        $onehot(temperature_avg_count) && temperature_avg_count[avgt_field])
        else $error("temperature count wrong");

    chk_avgp_power: assert property (@(posedge clk) disable iff (!rstn)
        avgp_field <= 4'h8 |-> $onehot(pressure_avg_count) && pressure_avg_count[avgp_field])
        else $error("pressure count wrong");

    chk_avgp_384: assert property (@(posedge clk) disable iff (!rstn)
        avgp_field == bar_pkg::AVGP_CODE_384 |-> pressure_avg_count == bar_pkg::AVGP_COUNT_384)
        else $error("pressure count 384 wrong");

    chk_avgp_512: assert property (@(posedge clk) disable iff (!rstn)
        avgp_field == bar_pkg::AVGP_CODE_512 |-> pressure_avg_count == bar_pkg::AVGP_COUNT_512)
        else $error("pressure count 512 wrong");

    chk_avgp_unused: assert property (@(posedge clk) disable iff (!rstn)
        avgp_field > bar_pkg::AVGP_CODE_512 |-> pressure_avg_count == 10'h000)
        else $error("unused pressure code not zero");

    chk_status_mirror: assert property (@(posedge clk) disable iff (!rstn)
        rstn |=> sample_status == $past(status_in) && interrupt_source_flags == $past(int_source_in))
        else $error("status mirror wrong");

    chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
        byte_rvalid |-> $past(byte_rd) && !$past(cmd_start))
        else $error("read valid without read");

    chk_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(byte_rd && !cmd_start) |=> $stable(byte_rdata))
        else $error("read data moved without read");

    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_CTRL_ONE) |=> control_one == $past(byte_wdata))
        else $error("control one not written");

    chk_icfg_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_INT_CFG) |=> interrupt_configuration == $past(byte_wdata))
        else $error("interrupt setup not written");

    chk_avg_write: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_at(bar_pkg::A_AVG_CFG) |=> averaging_configuration == $past(byte_wdata))
        else $error("averaging not written");

    chk_ro_drop: assert property (@(posedge clk) disable iff (!rstn)
        seq_write_ro |=> $stable(ref_pressure) && $stable(averaging_configuration) && $stable(control_one))
        else $error("read-only write changed a register");

    chk_result_hold: assert property (@(posedge clk) disable iff (!rstn)
        !sum_valid |=> $stable(pressure_result) && $stable(temperature_result))
        else $error("result moved without sample");
endmodule

//--- src/bar_pkg.sv
// Purpose: shared constants of the barometer register map
// Assumes: 8-bit registers, 7-bit register address
// Notes: all offsets are register addresses, not byte addresses
package bar_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] A_REF_LOW = 7'h08;
    localparam logic [6:0] A_REF_MID = 7'h09;
    localparam logic [6:0] A_REF_HIGH = 7'h0a;
    localparam logic [6:0] A_IDENTITY = 7'h0f;
    localparam logic [6:0] A_AVG_CFG = 7'h10;
    localparam logic [6:0] A_CTRL_ONE = 7'h20;
    localparam logic [6:0] A_CTRL_TWO = 7'h21;
    localparam logic [6:0] A_CTRL_THREE = 7'h22;
    localparam logic [6:0] A_INT_CFG = 7'h23;
    localparam logic [6:0] A_INT_SRC = 7'h24;
    localparam logic [6:0] A_THS_LOW = 7'h25;
    localparam logic [6:0] A_THS_HIGH = 7'h26;
    localparam logic [6:0] A_STATUS = 7'h27;
    localparam logic [6:0] A_PRESS_LOW = 7'h28;
    localparam logic [6:0] A_PRESS_MID = 7'h29;
    localparam logic [6:0] A_PRESS_HIGH = 7'h2a;
    localparam logic [6:0] A_TEMP_LOW = 7'h2b;
    localparam logic [6:0] A_TEMP_HIGH = 7'h2c;
    localparam logic [6:0] A_AMPLIFIER_CONTROL = 7'h30;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_AVG_CFG = 8'h7a;
    // averaging field positions
    localparam int AVGP_LSB = 0;
    localparam int AVGP_W = 4;
    localparam int AVGT_LSB = 4;
    localparam int AVGT_W = 3;
    localparam logic [3:0] AVGP_CODE_384 = 4'h9;
    localparam logic [3:0] AVGP_CODE_512 = 4'ha;
    localparam logic [9:0] AVGP_COUNT_384 = 10'h180;
    localparam logic [9:0] AVGP_COUNT_512 = 10'h200;
    localparam int PCOUNT_W = 10;
    localparam int TCOUNT_W = 8;
    // identity value is arbitrary
    localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a;
    // calibration trim value is arbitrary
    localparam logic [7:0] AMP_TRIM_DEFAULT = 8'h00;
    localparam int READ_LATENCY = 1;
endpackage

//--- src/bar_avg_decode.sv
// Purpose: turns averaging codes into sample counts
// Assumes: codes above ten on the pressure field are unused
// Notes: unused codes decode to a count of zero
module bar_avg_decode (
    input wire logic [3:0] avgp_code,
    input wire logic [2:0] avgt_code,
    output logic [9:0] pressure_count,
    output logic [7:0] temperature_count
);
    assign pressure_count = (avgp_code <= 4'h8) ? (10'h001 << avgp_code) :
        (avgp_code == bar_pkg::AVGP_CODE_384) ? bar_pkg::AVGP_COUNT_384 :
        (avgp_code == bar_pkg::AVGP_CODE_512) ? bar_pkg::AVGP_COUNT_512 : 10'h000;
    assign temperature_count = 8'h01 << avgt_code;
endmodule

//--- src/bar_ref_adder.sv
// Purpose: adds the reference pressure to each new raw sample
// Assumes: both operands are 24-bit two's complement
// Notes: the sum wraps modulo 2^24
module bar_ref_adder (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [23:0] raw_pressure,
    input wire logic [23:0] ref_pressure,
    output logic [23:0] pressure_sum,
    output logic sum_valid
);
    logic [23:0] next_sum;

    assign next_sum = 24'(raw_pressure + ref_pressure);

    // capture on each sample
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pressure_sum <= 24'h000000;
            sum_valid <= 1'b0;
        end else begin
            sum_valid <= load;
            if (load) begin
                pressure_sum <= next_sum;
            end
        end
    end

    chk_sum_value: assert property (@(posedge clk) disable iff (!rstn)
        load |=> sum_valid && pressure_sum == 24'($past(raw_pressure) + $past(ref_pressure)))
        else $error("reference sum wrong");
endmodule

//--- tb/bar_host_model.sv
// Purpose: host controller side of the register port
// Assumes: one start per transfer, then byte strobes
// Notes: strobes rise at one edge and drop at the next; idle data is inverted
module bar_host_model (
    input wire logic clk,
    output logic cmd_start,
    output logic [6:0] cmd_addr,
    output logic cmd_incr,
    output logic byte_wr,
    output logic [7:0] byte_wdata,
    output logic byte_rd,
    input wire logic [7:0] byte_rdata,
    input wire logic byte_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial begin
        cmd_start = 1'b0;
        cmd_addr = 7'h55;
        cmd_incr = 1'b0;
        byte_wr = 1'b0;
        byte_wdata = 8'ha5;
        byte_rd = 1'b0;
    end
    task automatic send_start(input logic [6:0] addr, input logic incr);
        @(posedge clk);
        cmd_start <= 1'b1;
        cmd_addr <= addr;
        cmd_incr <= incr;
        @(posedge clk);
        cmd_start <= 1'b0;
        cmd_addr <= ~addr;
        cmd_incr <= ~incr;
    endtask
    // caller never targets reserved or trim
    task automatic send_byte(input logic [7:0] data);
        @(posedge clk);
        byte_wr <= 1'b1;
        byte_wdata <= data;
        @(posedge clk);
        byte_wr <= 1'b0;
        byte_wdata <= ~data;
    endtask
    // bounded wait for the read answer
    task automatic fetch_byte(output logic [7:0] data, output logic ok);
        int n;
        data = 8'h00;
        ok = 1'b0;
        @(posedge clk);
        byte_rd <= 1'b1;
        @(posedge clk);
        byte_rd <= 1'b0;
        for (n = 0; n < 4 && ok == 1'b0; n++) begin
            #1;
            if (byte_rvalid === 1'b1) begin
                data = byte_rdata;
                ok = 1'b1;
            end else begin
                @(posedge clk);
            end
        end
    endtask
endmodule

//--- tb/tb_barometer_register_map.sv
// Purpose: self-checking bench of the register map
// Assumes: host model drives the register port, bench drives the engine side
// Notes: identity parameter is set to an arbitrary value
module tb_barometer_register_map;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary identity value
    localparam logic [7:0] TRIM_CODE = 8'h96; // arbitrary trim value
    localparam logic [7:0] WB [7] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6, 8'h07};
    localparam logic [6:0] RA [18] = '{7'h08, 7'h09, 7'h0a, 7'h0f, 7'h10, 7'h20, 7'h21, 7'h22, 7'h23,
        7'h25, 7'h26, 7'h30, 7'h24, 7'h27, 7'h05, 7'h0d, 7'h1f, 7'h2d};
    localparam logic [7:0] RE [18] = '{8'h00, 8'h00, 8'h00, 8'h3c, 8'h7a, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h96, 8'ha3, 8'h5c, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [6:0] RO_A [4] = '{7'h0f, 7'h24, 7'h27, 7'h28};
    localparam logic [7:0] RO_E [4] = '{8'h3c, 8'ha3, 8'h5c, 8'h00};
    logic clk, rstn, cmd_start, cmd_incr, byte_wr, byte_rd, byte_rvalid, sample_load;
    logic [6:0] cmd_addr;
    logic [7:0] byte_wdata, byte_rdata, status_in, int_source_in, temperature_avg_count, control_one;
    logic [7:0] control_two, control_three, interrupt_configuration, pressure_threshold_low;
    logic [7:0] pressure_threshold_high, amplifier_control;
    logic [23:0] raw_pressure, ref_pressure;
    logic [15:0] raw_temperature;
    logic [9:0] pressure_avg_count, pexp;
    int failures, tests_run, i;

    bar_register_map #(.IDENTITY(ID_CODE), .AMP_TRIM(TRIM_CODE)) i_dut (.clk(clk), .rstn(rstn), .cmd_start(cmd_start),
        .cmd_addr(cmd_addr), .cmd_incr(cmd_incr), .byte_wr(byte_wr), .byte_wdata(byte_wdata),
        .byte_rd(byte_rd), .byte_rdata(byte_rdata), .byte_rvalid(byte_rvalid), .sample_load(sample_load),
        .raw_pressure(raw_pressure), .raw_temperature(raw_temperature), .status_in(status_in),
        .int_source_in(int_source_in), .ref_pressure(ref_pressure), .pressure_avg_count(pressure_avg_count),
        .temperature_avg_count(temperature_avg_count), .control_one(control_one), .control_two(control_two),
        .control_three(control_three), .interrupt_configuration(interrupt_configuration),
        .pressure_threshold_low(pressure_threshold_low), .pressure_threshold_high(pressure_threshold_high),
        .amplifier_control(amplifier_control));
    bar_host_model i_host (.clk(clk), .cmd_start(cmd_start), .cmd_addr(cmd_addr), .cmd_incr(cmd_incr),
        .byte_wr(byte_wr), .byte_wdata(byte_wdata), .byte_rd(byte_rd), .byte_rdata(byte_rdata),
        .byte_rvalid(byte_rvalid));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // compare seen against expected
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one read at the current pointer
    task automatic expect_rd(input string what, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_host.fetch_byte(d, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch %s expected rvalid seen none", what);
            tally_and_finish();
        end
        check(what, {16'h0000, d}, {16'h0000, exp});
    endtask
    // reset held 20 cycles
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
    endtask

    // main sequence
    initial begin
        rstn = 1'b0;
        sample_load = 1'b0;
        raw_pressure = 24'h000000;
        raw_temperature = 16'h0000;
        status_in = 8'h5c;
        int_source_in = 8'ha3;
        failures = 0;
        tests_run = 0;
        do_reset();
        // reset values, mirrors and reserved reads
        for (i = 0; i < 18; i++) begin
            i_host.send_start(RA[i], 1'b0);
            expect_rd("reset value", RE[i]);
        end
        // incrementing burst into the reference, negative value
        i_host.send_start(7'h08, 1'b1);
        i_host.send_byte(8'h11);
        i_host.send_byte(8'h22);
        i_host.send_byte(8'hc3);
        #1;
        check("ref_pressure", ref_pressure, 24'hc32211);
        i_host.send_start(7'h08, 1'b1);
        expect_rd("ref low", 8'h11);
        expect_rd("ref mid", 8'h22);
        expect_rd("ref high", 8'hc3);
        // reference of minus five added to a raw sample
        i_host.send_start(7'h08, 1'b1);
        i_host.send_byte(8'hfb);
        i_host.send_byte(8'hff);
        i_host.send_byte(8'hff);
        @(posedge clk);
        sample_load <= 1'b1;
        raw_pressure <= 24'h000105;
        raw_temperature <= 16'h1234;
        @(posedge clk);
        sample_load <= 1'b0;
        raw_pressure <= 24'hfffefa;
        raw_temperature <= 16'hedcb;
        repeat (3) @(posedge clk);
        i_host.send_start(7'h28, 1'b1);
        expect_rd("press low", 8'h00);
        expect_rd("press mid", 8'h01);
        expect_rd("press high", 8'h00);
        expect_rd("temp low", 8'h34);
        expect_rd("temp high", 8'h12);
        // writes to read-only places are dropped
        for (i = 0; i < 4; i++) begin
            i_host.send_start(RO_A[i], 1'b0);
            i_host.send_byte(8'hff);
            expect_rd("read-only", RO_E[i]);
        end
        // fixed pointer keeps the last byte at one address
        i_host.send_start(7'h20, 1'b0);
        i_host.send_byte(8'h81);
        i_host.send_byte(8'h42);
        #1;
        check("control_one", {16'h0000, control_one}, 24'h000042);
        i_host.send_start(7'h21, 1'b0);
        expect_rd("control two", 8'h00);
        // every averaging code; output rate stays one shot so 7a is allowed
        for (i = 0; i < 16; i++) begin
            i_host.send_start(7'h10, 1'b0);
            i_host.send_byte({1'b0, i[2:0], i[3:0]});
            @(posedge clk);
            pexp = (i <= 8) ? (10'h001 << i) : ((i == 9) ? 10'h180 : ((i == 10) ? 10'h200 : 10'h000));
            check("pressure count", {14'h0000, pressure_avg_count}, {14'h0000, pexp});
            check("temp count", {16'h0000, temperature_avg_count}, 24'h000001 << i[2:0]);
            expect_rd("avg config", {1'b0, i[2:0], i[3:0]});
        end
        // burst over controls and setup; 24 is read-only and drops its byte
        i_host.send_start(7'h20, 1'b1);
        for (i = 0; i < 7; i++) begin
            i_host.send_byte(WB[i]);
        end
        #1;
        check("control_one", {16'h0000, control_one}, 24'h0000a1);
        check("control_two", {16'h0000, control_two}, 24'h0000b2);
        check("control_three", {16'h0000, control_three}, 24'h0000c3);
        check("int config", {16'h0000, interrupt_configuration}, 24'h0000d4);
        check("ths low", {16'h0000, pressure_threshold_low}, 24'h0000f6);
        check("ths high", {16'h0000, pressure_threshold_high}, 24'h000007);
        check("trim", {16'h0000, amplifier_control}, {16'h0000, TRIM_CODE});
        // new engine status is mirrored
        @(posedge clk);
        status_in <= 8'h3a;
        int_source_in <= 8'hc5;
        i_host.send_start(7'h24, 1'b1);
        expect_rd("int source", 8'hc5);
        expect_rd("ths low rd", 8'hf6);
        expect_rd("ths high rd", 8'h07);
        expect_rd("status", 8'h3a);
        // second reset restores the defaults
        do_reset();
        @(posedge clk);
        check("ref after reset", ref_pressure, 24'h000000);
        check("trim after reset", {16'h0000, amplifier_control}, {16'h0000, TRIM_CODE});
        check("ths high after reset", {16'h0000, pressure_threshold_high}, 24'h000000);
        check("control_two after reset", {16'h0000, control_two}, 24'h000000);
        i_host.send_start(7'h10, 1'b0);
        expect_rd("avg after reset", 8'h7a);
        tally_and_finish();
    end
endmodule
